// *** comparator_control_output.sv ***
// Control, output routing and register slave for two comparator channels
`timescale 1ns/1ps
module comparator_control_output (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [1:0] rawCompare,
    input wire logic timerSourceClock,
    input wire logic [comparator_control_pkg::PORT_WIDTH-1:0] portPins,
    output logic [1:0] comparatorOn,
    output logic [1:0] speedPowerSelect,
    output logic [1:0] hysteresisOn,
    output logic [1:0] gateSource,
    output logic pwmShutdown,
    output comparator_control_pkg::pin_drive_type firstResultPin,
    output comparator_control_pkg::pin_drive_type secondResultPin
);
    localparam int PW = comparator_control_pkg::PORT_WIDTH;

    comparator_control_pkg::state_type s_q;
    comparator_control_pkg::state_type s_d;
    logic [1:0] rawSync;
    logic timerSync;
    logic [PW-1:0] portSync;
    logic [1:0] resultNow;
    logic timerFall;
    logic shutTrigger;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    two_flop_sync #(.WIDTH(PW + 3)) inputSync (
        .clock(clock),
        .rst(rst),
        .asyncIn({rawCompare, timerSourceClock, portPins}),
        .syncOut({rawSync, timerSync, portSync})
    );

    function automatic logic [7:0] controlByte(input comparator_control_pkg::control_type c,
                                               input logic result);
        logic [7:0] b;
        b = 8'h00;
        b[comparator_control_pkg::ON_BIT] = c.comparatorOn;
        b[comparator_control_pkg::RESULT_BIT] = result;
        b[comparator_control_pkg::DRIVE_BIT] = c.pinDriveEnable;
        b[comparator_control_pkg::INVERT_BIT] = c.resultInvert;
        b[comparator_control_pkg::SPEED_BIT] = c.speedPowerSelect;
        b[comparator_control_pkg::HYST_BIT] = c.hysteresisOn;
        b[comparator_control_pkg::SYNC_BIT] = c.timerSyncOn;
        return b;
    endfunction

    function automatic comparator_control_pkg::control_type controlWrite(input logic [7:0] b);
        comparator_control_pkg::control_type c;
        c.comparatorOn = b[comparator_control_pkg::ON_BIT];
        c.pinDriveEnable = b[comparator_control_pkg::DRIVE_BIT];
        c.resultInvert = b[comparator_control_pkg::INVERT_BIT];
        c.speedPowerSelect = b[comparator_control_pkg::SPEED_BIT];
        c.hysteresisOn = b[comparator_control_pkg::HYST_BIT];
        c.timerSyncOn = b[comparator_control_pkg::SYNC_BIT];
        return c;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        timerFall = s_q.timerPrev & ~timerSync;
        s_d.timerPrev = timerSync;
        for (int i = 0; i < 2; i++) begin
            // Disabled comparator contributes no input, only the inversion
            resultNow[i] = (s_q.ctrl[i].comparatorOn & rawSync[i]) ^ s_q.ctrl[i].resultInvert;
            if (timerFall) begin
                s_d.latched[i] = resultNow[i];
            end
            s_d.gate[i] = s_q.ctrl[i].timerSyncOn ? s_q.latched[i] : resultNow[i];
            s_d.pin[i].out = s_d.gate[i];
            s_d.pin[i].oe = s_q.ctrl[i].pinDriveEnable & ~s_q.dirInput[i];
        end
        // PWM shutdown from selected results
        shutTrigger = s_q.shutEnable & |(s_q.shutSelect & s_q.gate);
        if (s_q.restartEnable) begin
            s_d.shutdown = shutTrigger;
        end else begin
            s_d.shutdown = s_q.shutdown | shutTrigger;
        end
        if (!s_q.shutEnable) begin
            s_d.shutdown = 1'b0;
        end
        // Register writes in data phase
        if (s_q.addrValid && s_q.addrWrite) begin
            unique case (s_q.addr)
                comparator_control_pkg::FIRST_CONTROL_ADDR: s_d.ctrl[0] = controlWrite(hwdata[7:0]);
                comparator_control_pkg::SECOND_CONTROL_ADDR: s_d.ctrl[1] = controlWrite(hwdata[7:0]);
                comparator_control_pkg::DIRECTION_ADDR: s_d.dirInput = hwdata[1:0];
                comparator_control_pkg::ANALOG_SELECT_ADDR: s_d.analogSel = hwdata[PW-1:0];
                comparator_control_pkg::SHUTDOWN_ADDR: begin
                    s_d.shutSelect = hwdata[1:0];
                    s_d.shutEnable = hwdata[comparator_control_pkg::SHUT_ENABLE_BIT];
                    s_d.restartEnable = hwdata[comparator_control_pkg::RESTART_BIT];
                    // Writing one clears the latched shutdown, a new trigger wins
                    if (hwdata[comparator_control_pkg::SHUT_STATUS_BIT] && !shutTrigger) begin
                        s_d.shutdown = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Address phase capture and read data
        s_d.addrValid = hsel & htrans[1] & hready;
        s_d.addrWrite = hwrite;
        s_d.addr = haddr[7:0];
        s_d.rdata = s_q.rdata;
        if (hsel && htrans[1] && hready && !hwrite) begin
            s_d.rdata = 32'h0000_0000;
            unique case (haddr[7:0])
                comparator_control_pkg::FIRST_CONTROL_ADDR:
                    s_d.rdata[7:0] = controlByte(s_d.ctrl[0], resultNow[0]);
                comparator_control_pkg::SECOND_CONTROL_ADDR:
                    s_d.rdata[7:0] = controlByte(s_d.ctrl[1], resultNow[1]);
                comparator_control_pkg::DIRECTION_ADDR: s_d.rdata[1:0] = s_d.dirInput;
                comparator_control_pkg::ANALOG_SELECT_ADDR: s_d.rdata[PW-1:0] = s_d.analogSel;
                comparator_control_pkg::PORT_DATA_ADDR:
                    s_d.rdata[PW-1:0] = portSync & ~s_d.analogSel;
                comparator_control_pkg::SHUTDOWN_ADDR: s_d.rdata[4:0] = {s_d.shutdown,
                    s_d.restartEnable, s_d.shutEnable, s_d.shutSelect};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= comparator_control_pkg::STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign pwmShutdown = s_q.shutdown;
    assign gateSource = s_q.gate;
    assign firstResultPin = s_q.pin[0];
    assign secondResultPin = s_q.pin[1];
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            comparatorOn[i] = s_q.ctrl[i].comparatorOn;
            speedPowerSelect[i] = s_q.ctrl[i].speedPowerSelect;
            hysteresisOn[i] = s_q.ctrl[i].hysteresisOn;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_pinFollowsGate;
        @(posedge clock) disable iff (rst)
            !s_q.ctrl[0].timerSyncOn |=> (firstResultPin.out == $past(resultNow[0]));
    endproperty
    a_pinFollowsGate: assert property (p_pinFollowsGate) else $error("pin differs from result");

    property p_pinDrive;
        @(posedge clock) disable iff (rst)
            s_q.pin[1].oe |-> $past(s_q.ctrl[1].pinDriveEnable && !s_q.dirInput[1]);
    endproperty
    a_pinDrive: assert property (p_pinDrive) else $error("pin driven without enable");

    property p_offLow;
        @(posedge clock) disable iff (rst)
            (!s_q.ctrl[0].comparatorOn && !s_q.ctrl[0].resultInvert && !s_q.ctrl[0].timerSyncOn)
            |=> (s_q.gate[0] == 1'b0);
    endproperty
    a_offLow: assert property (p_offLow) else $error("disabled comparator not low");

    property p_invertOff;
        @(posedge clock) disable iff (rst)
            (!s_q.ctrl[1].comparatorOn && s_q.ctrl[1].resultInvert && !s_q.ctrl[1].timerSyncOn)
            |=> (s_q.gate[1] == 1'b1);
    endproperty
    a_invertOff: assert property (p_invertOff) else $error("inversion not applied");

    property p_syncHold;
        @(posedge clock) disable iff (rst) !timerFall |=> $stable(s_q.latched);
    endproperty
    a_syncHold: assert property (p_syncHold) else $error("latch moved without timer edge");

    property p_syncGate;
        @(posedge clock) disable iff (rst)
            (s_q.ctrl[0].timerSyncOn && !timerFall)[*2] |-> (s_q.gate[0] == s_q.latched[0]);
    endproperty
    a_syncGate: assert property (p_syncGate) else $error("synced result not latched");

    property p_shutSet;
        @(posedge clock) disable iff (rst) shutTrigger |=> pwmShutdown;
    endproperty
    a_shutSet: assert property (p_shutSet) else $error("shutdown missed");

    property p_restart;
        @(posedge clock) disable iff (rst)
            (s_q.restartEnable && !shutTrigger && !(s_q.addrValid && s_q.addrWrite))
            |=> !pwmShutdown;
    endproperty
    a_restart: assert property (p_restart) else $error("auto restart failed");

    property p_shutOff;
        @(posedge clock) disable iff (rst) !s_q.shutEnable |=> !pwmShutdown;
    endproperty
    a_shutOff: assert property (p_shutOff) else $error("shutdown without enable");

    property p_portZero;
        @(posedge clock) disable iff (rst)
            (s_q.addrValid && !s_q.addrWrite && s_q.addr == comparator_control_pkg::PORT_DATA_ADDR)
            |-> ((hrdata[PW-1:0] & s_q.analogSel) == '0);
    endproperty
    a_portZero: assert property (p_portZero) else $error("analog pin read nonzero");

    property p_reservedZero;
        @(posedge clock) disable iff (rst)
            (s_q.addrValid && !s_q.addrWrite && s_q.addr == comparator_control_pkg::FIRST_CONTROL_ADDR)
            |-> (hrdata[3] == 1'b0 && hrdata[31:8] == 24'h000000);
    endproperty
    a_reservedZero: assert property (p_reservedZero) else $error("reserved bits set");
endmodule

// *** comparator_control_pkg.sv ***
// Package with register map, reset values and state types of the comparator control block
package comparator_control_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FIRST_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] SECOND_CONTROL_ADDR = 8'h04;
    localparam logic [7:0] DIRECTION_ADDR = 8'h08;
    localparam logic [7:0] ANALOG_SELECT_ADDR = 8'h0c;
    localparam logic [7:0] PORT_DATA_ADDR = 8'h10;
    localparam logic [7:0] SHUTDOWN_ADDR = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ON_BIT = 7;
    localparam int RESULT_BIT = 6;
    localparam int DRIVE_BIT = 5;
    localparam int INVERT_BIT = 4;
    localparam int SPEED_BIT = 2;
    localparam int HYST_BIT = 1;
    localparam int SYNC_BIT = 0;
    localparam int SHUT_ENABLE_BIT = 2;
    localparam int RESTART_BIT = 3;
    localparam int SHUT_STATUS_BIT = 4;
    localparam int PORT_WIDTH = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic comparatorOn;
        logic pinDriveEnable;
        logic resultInvert;
        logic speedPowerSelect;
        logic hysteresisOn;
        logic timerSyncOn;
    } control_type;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_type;

    typedef struct packed {
        control_type [1:0] ctrl;
        logic [1:0] dirInput;
        logic [PORT_WIDTH-1:0] analogSel;
        logic [1:0] shutSelect;
        logic shutEnable;
        logic restartEnable;
        logic shutdown;
        logic [1:0] latched;
        logic timerPrev;
        logic [1:0] gate;
        pin_drive_type [1:0] pin;
        logic addrValid;
        logic addrWrite;
        logic [7:0] addr;
        logic [31:0] rdata;
    } state_type;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam control_type CONTROL_RESET = '{speedPowerSelect: 1'b1, default: 1'b0};
    localparam logic [1:0] DIRECTION_RESET = 2'h3;
    localparam logic [PORT_WIDTH-1:0] ANALOG_RESET = 8'hff;
    localparam state_type STATE_RESET = '{
        ctrl: {CONTROL_RESET, CONTROL_RESET},
        dirInput: DIRECTION_RESET,
        analogSel: ANALOG_RESET,
        default: '0
    };

endpackage

// *** two_flop_sync.sv ***
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module two_flop_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage_q <= '0;
            syncOut <= '0;
        end else begin
            stage_q <= asyncIn;
            syncOut <= stage_q;
        end
    end
endmodule

// *** comparator_far_side.sv ***
// Behavioural far side: two analog comparators, timer clock source and port pins
`timescale 1ns/1ps
module comparator_far_side (
    input wire logic [1:0] compareLevel,
    input wire logic timerLevel,
    input wire logic [7:0] pinLevel,
    output logic [1:0] rawCompare,
    output logic timerSourceClock,
    output logic [7:0] portPins
);
    // ------------------------------------------------------------
    // Analog side, one comparator per channel
    // ------------------------------------------------------------
    assign rawCompare = compareLevel;
    // Timer clock stands still until the bench moves it
    assign timerSourceClock = timerLevel;
    assign portPins = pinLevel;
endmodule

// *** testbench.sv ***
// Self-checking testbench for the comparator control block
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [7:0] wdata;
        logic raw;
        logic [7:0] expRead;
        logic expResult;
    } row_type;

    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [1:0] compareLevel = 2'h0;
    logic timerLevel = 1'b1;
    logic [7:0] pinLevel = 8'ha5;
    logic [1:0] rawCompare;
    logic timerSourceClock;
    logic [7:0] portPins;
    logic [1:0] comparatorOn;
    logic [1:0] speedPowerSelect;
    logic [1:0] hysteresisOn;
    logic [1:0] gateSource;
    logic pwmShutdown;
    comparator_control_pkg::pin_drive_type firstResultPin;
    comparator_control_pkg::pin_drive_type secondResultPin;
    comparator_control_pkg::pin_drive_type pin;
    logic [31:0] rd;
    logic [7:0] ctrlAddr;
    row_type r;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    row_type rows [0:7] = '{'{8'hfe, 1'b1, 8'hb6, 1'b0}, '{8'h80, 1'b1, 8'hc0, 1'b1},
        '{8'h80, 1'b0, 8'h80, 1'b0}, '{8'h90, 1'b0, 8'hd0, 1'b1},
        '{8'h30, 1'b1, 8'h70, 1'b1}, '{8'h00, 1'b1, 8'h00, 1'b0},
        '{8'ha6, 1'b1, 8'he6, 1'b1}, '{8'h08, 1'b1, 8'h00, 1'b0}};

    comparator_far_side far (.compareLevel(compareLevel), .timerLevel(timerLevel),
        .pinLevel(pinLevel), .rawCompare(rawCompare), .timerSourceClock(timerSourceClock),
        .portPins(portPins));

    comparator_control_output dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rawCompare(rawCompare),
        .timerSourceClock(timerSourceClock), .portPins(portPins), .comparatorOn(comparatorOn),
        .speedPowerSelect(speedPowerSelect), .hysteresisOn(hysteresisOn),
        .gateSource(gateSource), .pwmShutdown(pwmShutdown), .firstResultPin(firstResultPin),
        .secondResultPin(secondResultPin));

    // ------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------
    initial begin
        forever #25 clock = ~clock;
    end

    task automatic test_done;
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("response", 32'(hresp), 32'h0);
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check("speed out", 32'(speedPowerSelect), 32'h3);
        rdchk("first ctrl", comparator_control_pkg::FIRST_CONTROL_ADDR, 32'h4);
        rdchk("second ctrl", comparator_control_pkg::SECOND_CONTROL_ADDR, 32'h4);
        bus(1'b1, comparator_control_pkg::DIRECTION_ADDR, 32'h0);
        for (int ch = 0; ch < 2; ch++) begin
            for (int i = 0; i < 8; i++) begin
                r = rows[i];
                ctrlAddr = (ch == 0) ? 8'h00 : 8'h04;
                bus(1'b1, ctrlAddr, {24'h0, r.wdata});
                compareLevel[ch] <= r.raw;
                tick(6);
                rdchk("ctrl", ctrlAddr, {24'h0, r.expRead});
                pin = (ch == 0) ? firstResultPin : secondResultPin;
                check("on", 32'(comparatorOn[ch]), 32'(r.wdata[7]));
                check("speed", 32'(speedPowerSelect[ch]), 32'(r.wdata[2]));
                check("hyst", 32'(hysteresisOn[ch]), 32'(r.wdata[1]));
                check("gate", 32'(gateSource[ch]), 32'(r.expResult));
                check("pin oe", 32'(pin.oe), 32'(r.wdata[5]));
                if (r.wdata[5])
                    check("pin out", 32'(pin.out), 32'(r.expResult));
            end
        end
        bus(1'b1, 8'h18, 32'h5a);
        rdchk("unmapped", 8'h18, 32'h0);
        bus(1'b1, comparator_control_pkg::ANALOG_SELECT_ADDR, 32'h0f);
        rdchk("port", comparator_control_pkg::PORT_DATA_ADDR, 32'ha0);
        bus(1'b1, comparator_control_pkg::ANALOG_SELECT_ADDR, 32'hff);
        rdchk("port all", comparator_control_pkg::PORT_DATA_ADDR, 32'h0);
        bus(1'b1, comparator_control_pkg::DIRECTION_ADDR, 32'h1);
        bus(1'b1, 8'h00, 32'ha0);
        bus(1'b1, 8'h04, 32'ha0);
        tick(3);
        check("oe input", 32'(firstResultPin.oe), 32'h0);
        check("oe output", 32'(secondResultPin.oe), 32'h1);
        bus(1'b1, 8'h00, 32'h80);
        compareLevel <= 2'h0;
        tick(6);
        rdchk("verify", 8'h00, 32'h80);
        bus(1'b1, 8'h00, 32'h81);
        compareLevel <= 2'h1;
        tick(8);
        check("sync hold", 32'(gateSource[0]), 32'h0);
        timerLevel <= 1'b0;
        tick(6);
        check("sync fall", 32'(gateSource[0]), 32'h1);
        timerLevel <= 1'b1;
        compareLevel <= 2'h0;
        tick(6);
        check("sync rise", 32'(gateSource[0]), 32'h1);
        bus(1'b1, 8'h00, 32'h80);
        tick(6);
        bus(1'b1, comparator_control_pkg::SHUTDOWN_ADDR, 32'h05);
        compareLevel <= 2'h1;
        tick(6);
        check("shut", 32'(pwmShutdown), 32'h1);
        compareLevel <= 2'h0;
        tick(6);
        check("shut held", 32'(pwmShutdown), 32'h1);
        rdchk("status", comparator_control_pkg::SHUTDOWN_ADDR, 32'h15);
        bus(1'b1, comparator_control_pkg::SHUTDOWN_ADDR, 32'h16);
        compareLevel <= 2'h1;
        tick(6);
        check("unselected", 32'(pwmShutdown), 32'h0);
        bus(1'b1, comparator_control_pkg::SHUTDOWN_ADDR, 32'h0e);
        compareLevel <= 2'h2;
        tick(6);
        check("restart shut", 32'(pwmShutdown), 32'h1);
        compareLevel <= 2'h0;
        tick(6);
        check("restart run", 32'(pwmShutdown), 32'h0);
        compareLevel <= 2'h2;
        tick(6);
        bus(1'b1, comparator_control_pkg::SHUTDOWN_ADDR, 32'h0a);
        tick(2);
        check("shut off", 32'(pwmShutdown), 32'h0);
        bus(1'b1, comparator_control_pkg::SHUTDOWN_ADDR, 32'h0e);
        tick(6);
        check("shut again", 32'(pwmShutdown), 32'h1);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        check("shut reset", 32'(pwmShutdown), 32'h0);
        rdchk("ctrl reset", 8'h00, 32'h4);
        test_done();
    end
endmodule
